// ==== core/rscs_cfg.svh ====
// Timing, reset values and default figures of the self check supervisor.
// Assumes a 200 MHz system clock; included by bare name.
`ifndef RSCS_CFG_SVH
`define RSCS_CFG_SVH

// System clock rate in MHz.
`define RSCS_CLK_MHZ 200
// Watchdog timeout in milliseconds, and the derived cycle count.
`define RSCS_WDOG_TIME_MS 100
`define RSCS_WDOG_CYC (`RSCS_WDOG_TIME_MS * 1000 * `RSCS_CLK_MHZ)
// Time the system reset line is held, in nanoseconds, and in cycles.
`define RSCS_RST_HOLD_NS 80
`define RSCS_RST_HOLD_CYC ((`RSCS_RST_HOLD_NS * `RSCS_CLK_MHZ) / 1000)
// Least spacing between two idle-time test runs, in microseconds and cycles.
`define RSCS_IDLE_GAP_US 5
`define RSCS_IDLE_GAP_CYC (`RSCS_IDLE_GAP_US * `RSCS_CLK_MHZ)
// Expected converter code for the reference taken from the 5 V rail.
`define RSCS_ADC_REF_CODE 12'h800
// Allowed deviation of the reference code either way.
`define RSCS_ADC_TOL 12'h010
// Default accumulated interruption duty, kA squared.
`define RSCS_DUTY_ACCUM_DFLT 16'h0000
// Default interruption duty limit, 8000 kA squared.
`define RSCS_DUTY_LIMIT_DFLT 16'h1f40
// Default permit mask: every external input allowed.
`define RSCS_PERMIT_DFLT 8'hff
// Reset value of a cleared flag.
`define RSCS_FLAG_CLR 1'b0

`endif

// ==== core/rscs_pkg.sv ====
// Types shared by the self check supervisor, its tester model, checker and bench.
// Assumes rscs_cfg.svh supplies the figures; this package holds types only.
package rscs_pkg;

  // Supervisor states.
  typedef enum logic [2:0] {
    ST_COLD,   // Cold boot: log and launch the start-up tests.
    ST_TEST,   // Waiting for the start-up test results.
    ST_WARM,   // Warm boot: variables initialised, logged.
    ST_RUN,    // Normal operation.
    ST_ITEST,  // Waiting for idle-time test results.
    ST_RSTI,   // System reset being initiated.
    ST_HALT    // Latched halt; only power removal leaves it.
  } rscs_state_t;

  // Results reported by the testers with the done strobe.
  typedef struct packed {
    logic adc_fail;      // Converter stuck or unresponsive.
    logic supply_unrec;  // 15 V supply lost beyond recovery.
    logic osc_ram_fail;  // Oscillography memory failed.
    logic work_ram_fail; // Working memory failed.
    logic evlog_fail;    // Event-log storage area failed.
    logic nv_chip_fail;  // Nonvolatile storage chip malfunction.
    logic set_a_bad;     // Settings copy A corrupted.
    logic set_b_bad;     // Settings copy B corrupted.
    logic cal_a_bad;     // Calibration copy A corrupted.
    logic cal_b_bad;     // Calibration copy B corrupted.
  } rscs_test_res_t;

  // Event strobes towards the event log, one cycle each.
  typedef struct packed {
    logic cold_boot;     // Cold boot started.
    logic warm_boot;     // Warm boot done.
    logic dflt_settings; // Default settings loaded.
    logic dflt_calib;    // Default calibration loaded.
    logic open_current;  // Current while breaker open.
    logic supply_fail;   // Supply loss found.
    logic osc_fault;     // Oscillography memory fault.
    logic evlog_fault;   // Event-log storage fault.
    logic hw_fault;      // Nonvolatile chip fault.
    logic sys_reset;     // System reset initiated.
  } rscs_events_t;

  // Permit bits of the external inputs.
  typedef struct packed {
    logic reclose_inhibit_input;
    logic extended_zone_pullback_input;
    logic channel_receive_input;
    logic reclose_cancel_input;
    logic reclose_initiate_input;
    logic line_pickup_input;
    logic trip_block_input;
    logic breaker_status_input;
  } rscs_permit_t;

  // Default settings image driven while fallback settings are in force.
  typedef struct packed {
    logic [15:0]  duty_accum; // Accumulated duty, kA squared.
    logic [15:0]  duty_limit; // Duty limit, kA squared.
    rscs_permit_t permit;     // External input permits.
  } rscs_dflt_set_t;

endpackage

// ==== core/rscs_watchdog.sv ====
// One program watchdog: expires when not kicked within its timeout.
// Assumes the kick is a one-cycle strobe from the supervised program.
`timescale 1ns/1ps
`default_nettype none

module rscs_watchdog #(
  parameter int unsigned CYC = 20000000 // Timeout in clock cycles.
) (
  input  wire logic clk,    // System clock.
  input  wire logic rst,    // Asynchronous reset, active high.
  input  wire logic run,    // Watchdog armed while high.
  input  wire logic kick,   // Restart strobe from the program.
  output logic      expired // One-cycle pulse on timeout.
);

  localparam int unsigned W = $clog2(CYC + 1);

  logic [W-1:0] cnt_q; // Cycles since the last kick.

  // Count up while armed; a kick or disarm restarts the count.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_q   <= '0;
      expired <= 1'b0;
    end else if (!run || kick) begin
      cnt_q   <= '0;
      expired <= 1'b0;
    end else if (cnt_q == W'(CYC - 1)) begin
      cnt_q   <= '0;
      expired <= 1'b1;
    end else begin
      cnt_q   <= cnt_q + W'(1);
      expired <= 1'b0;
    end
  end

endmodule

`default_nettype wire

// ==== core/rscs_supervisor.sv ====
// Self check supervisor of a line protection relay.
// Assumes external testers run each test on test_start and answer with
// test_done and the result struct; one clock, reset means power-up.
`timescale 1ns/1ps
`default_nettype none
`include "rscs_cfg.svh"

module rscs_supervisor #(
  parameter int unsigned WDOG_CYC = `RSCS_WDOG_CYC, // Watchdog timeout.
  parameter int unsigned ADC_W    = 12              // Converter width.
) (
  input  wire logic                    clk,             // 200 MHz clock.
  input  wire logic                    rst,             // Power-up reset.
  input  wire logic                    idle,            // No protection work.
  input  wire logic                    test_done,       // Results valid.
  input  wire rscs_pkg::rscs_test_res_t test_res,       // Test results.
  input  wire logic [ADC_W-1:0]        adc_ref_code,    // Reference sample.
  input  wire logic                    wdog_kick_a,     // Kick, watchdog A.
  input  wire logic                    wdog_kick_b,     // Kick, watchdog B.
  input  wire logic                    breaker_open,    // Breaker is open.
  input  wire logic                    current_present, // Line current seen.
  input  wire logic                    settings_written,// User wrote settings.
  output logic                         test_start,      // Launch tests.
  output logic                         test_idle,       // Run is idle-time.
  output logic                         sys_reset,       // System reset line.
  output logic                         alarm,           // Alarm contact.
  output logic                         outputs_en,      // Outputs enabled.
  output logic                         trip_en,         // Tripping enabled.
  output logic                         protection_en,   // Protection on.
  output logic                         recloser_en,     // Reclosing on.
  output logic                         comms_en,        // Comms enabled.
  output logic                         ready_led,       // Ready indicator.
  output logic                         error_msg,       // Show error text.
  output logic                         out_of_service,  // Out of service.
  output logic                         hardware_fault_flag, // Chip fault.
  output logic                         dflt_settings_flag,  // Fallback set.
  output logic                         dflt_calib_flag, // Fallback calib.
  output logic                         open_current_alarm, // Open with I.
  output logic                         osc_fault,       // Osc memory bad.
  output logic                         evlog_fault,     // Event store bad.
  output logic                         set_copy_b,      // Settings from B.
  output logic                         cal_copy_b,      // Calib from B.
  output rscs_pkg::rscs_dflt_set_t     dflt_set,        // Default settings.
  output rscs_pkg::rscs_events_t       events           // Event strobes.
);

  localparam logic [ADC_W-1:0] ADC_HI =
    ADC_W'(`RSCS_ADC_REF_CODE + `RSCS_ADC_TOL);
  localparam logic [ADC_W-1:0] ADC_LO =
    ADC_W'(`RSCS_ADC_REF_CODE - `RSCS_ADC_TOL);
  localparam int unsigned RST_CYC = (`RSCS_RST_HOLD_CYC < 1) ?
    1 : `RSCS_RST_HOLD_CYC;
  localparam int unsigned GAP_CYC = `RSCS_IDLE_GAP_CYC;
  localparam int unsigned RW = $clog2(RST_CYC + 1);
  localparam int unsigned GW = $clog2(GAP_CYC + 1);

  rscs_pkg::rscs_state_t state_q;  // Supervisor state.
  logic [RW-1:0]         rst_cnt_q; // Reset hold counter.
  logic [GW-1:0]         gap_cnt_q; // Idle spacing counter.
  logic                  wdog_exp_a; // Watchdog A expiry.
  logic                  wdog_exp_b; // Watchdog B expiry.
  logic                  wdog_exp;   // Either watchdog expired.
  logic                  wdog_run;   // Watchdogs armed.
  logic                  take;       // Results accepted this cycle.
  logic                  adc_bad;    // Converter check failed.
  logic                  crit;       // Critical fault in results.
  logic                  set_both;   // Both settings copies bad.
  logic                  cal_both;   // Both calibration copies bad.
  logic                  running;    // Warm-booted and operating.
  logic                  gap_done;   // Idle spacing elapsed.
  logic                  open_cur_q; // Open-with-current, last cycle.

  // Two independent program watchdogs, armed in every state but ST_HALT.
  // two watchdogs
  rscs_watchdog #(.CYC(WDOG_CYC)) u_wdog_a (
    .clk     (clk),
    .rst     (rst),
    .run     (wdog_run),
    .kick    (wdog_kick_a),
    .expired (wdog_exp_a)
  );

  rscs_watchdog #(.CYC(WDOG_CYC)) u_wdog_b (
    .clk     (clk),
    .rst     (rst),
    .run     (wdog_run),
    .kick    (wdog_kick_b),
    .expired (wdog_exp_b)
  );

  // Classify the results; only results awaited in a test state count.
  always_comb begin
    wdog_run = (state_q != rscs_pkg::ST_HALT);
    wdog_exp = wdog_exp_a | wdog_exp_b;
    take     = test_done & ((state_q == rscs_pkg::ST_TEST) |
                            (state_q == rscs_pkg::ST_ITEST));
    adc_bad  = test_res.adc_fail | (adc_ref_code > ADC_HI) |
               (adc_ref_code < ADC_LO);
    crit     = adc_bad | test_res.supply_unrec | test_res.work_ram_fail;
    set_both = test_res.set_a_bad & test_res.set_b_bad;
    cal_both = test_res.cal_a_bad & test_res.cal_b_bad;
    running  = (state_q == rscs_pkg::ST_RUN) |
               (state_q == rscs_pkg::ST_ITEST);
    gap_done = (gap_cnt_q == GW'(GAP_CYC));
  end

  // Main sequence: cold boot, tests, warm boot, run, idle tests, halt.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q    <= rscs_pkg::ST_COLD;
      test_start <= 1'b0;
      test_idle  <= 1'b0;
    end else begin
      test_start <= 1'b0;
      case (state_q)
        rscs_pkg::ST_COLD: begin
          test_start <= 1'b1;
          test_idle  <= 1'b0;
          state_q    <= rscs_pkg::ST_TEST;
        end
        rscs_pkg::ST_TEST: begin
          if (wdog_exp) begin
            state_q <= rscs_pkg::ST_HALT;
          end else if (take && (crit || test_res.nv_chip_fail)) begin
            state_q <= rscs_pkg::ST_HALT;
          end else if (take) begin
            state_q <= rscs_pkg::ST_WARM;
          end
        end
        rscs_pkg::ST_WARM: begin
          state_q <= rscs_pkg::ST_RUN;
        end
        rscs_pkg::ST_RUN: begin
          if (wdog_exp) begin
            state_q <= rscs_pkg::ST_RSTI;
          end else if (idle && gap_done) begin
            test_start <= 1'b1;
            test_idle  <= 1'b1;
            state_q    <= rscs_pkg::ST_ITEST;
          end
        end
        rscs_pkg::ST_ITEST: begin
          if (take && test_res.nv_chip_fail) begin
            state_q <= rscs_pkg::ST_HALT;
          end else if (wdog_exp || (take && crit)) begin
            state_q <= rscs_pkg::ST_RSTI;
          end else if (take) begin
            state_q <= rscs_pkg::ST_RUN;
          end
        end
        rscs_pkg::ST_RSTI: begin
          if (wdog_exp) begin
            state_q <= rscs_pkg::ST_HALT;
          end else if (rst_cnt_q == RW'(RST_CYC - 1)) begin
            state_q <= rscs_pkg::ST_COLD;
          end
        end
        rscs_pkg::ST_HALT: begin
          state_q <= rscs_pkg::ST_HALT;
        end
        default: begin
          state_q <= rscs_pkg::ST_HALT;
        end
      endcase
    end
  end

  // Reset hold and idle spacing counters.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rst_cnt_q <= '0;
      gap_cnt_q <= '0;
    end else begin
      if (state_q == rscs_pkg::ST_RSTI) begin
        rst_cnt_q <= rst_cnt_q + RW'(1);
      end else begin
        rst_cnt_q <= '0;
      end
      if (state_q != rscs_pkg::ST_RUN) begin
        gap_cnt_q <= '0;
      end else if (!gap_done) begin
        gap_cnt_q <= gap_cnt_q + GW'(1);
      end
    end
  end

  // Settings copy handling and the fallback-settings flag.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dflt_settings_flag <= `RSCS_FLAG_CLR;
      set_copy_b         <= 1'b0;
    end else begin
      if (take && set_both) begin
        dflt_settings_flag <= 1'b1;
      end else if (settings_written) begin
        dflt_settings_flag <= `RSCS_FLAG_CLR;
      end
      if (take) begin
        set_copy_b <= test_res.set_a_bad & ~test_res.set_b_bad;
      end
    end
  end

  // Calibration copy handling; fallback lasts until the next power-up.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dflt_calib_flag <= `RSCS_FLAG_CLR;
      cal_copy_b      <= 1'b0;
    end else if (take) begin
      if (cal_both) begin
        dflt_calib_flag <= 1'b1;
      end
      cal_copy_b <= test_res.cal_a_bad & ~test_res.cal_b_bad;
    end
  end

  // Sticky fault flags: hardware chip fault and non-critical areas.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hardware_fault_flag <= `RSCS_FLAG_CLR;
      osc_fault           <= `RSCS_FLAG_CLR;
      evlog_fault         <= `RSCS_FLAG_CLR;
    end else if (take) begin
      if (test_res.nv_chip_fail) begin
        hardware_fault_flag <= 1'b1;
      end
      if (test_res.osc_ram_fail) begin
        osc_fault <= 1'b1;
      end
      if (test_res.evlog_fail) begin
        evlog_fault <= 1'b1;
      end
    end
  end

  // Breaker position against current, checked every cycle.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      open_cur_q <= 1'b0;
    end else begin
      open_cur_q <= breaker_open & current_present;
    end
  end

  // Event strobes, one cycle each, several may fire together.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      events <= '0;
    end else begin
      events <= '0;
      events.cold_boot <= (state_q == rscs_pkg::ST_COLD);
      events.warm_boot <= (state_q == rscs_pkg::ST_WARM);
      events.sys_reset <= (state_q == rscs_pkg::ST_RSTI) &&
                          (rst_cnt_q == '0);
      events.open_current <= breaker_open & current_present & ~open_cur_q;
      if (take) begin
        events.dflt_settings <= set_both;
        events.dflt_calib    <= cal_both;
        events.supply_fail   <= test_res.supply_unrec;
        events.osc_fault     <= test_res.osc_ram_fail;
        events.evlog_fault   <= test_res.evlog_fail;
        events.hw_fault      <= test_res.nv_chip_fail;
      end
    end
  end

  // Registered status outputs derived from state and flags.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sys_reset          <= 1'b0;
      alarm              <= 1'b0;
      outputs_en         <= 1'b0;
      trip_en            <= 1'b0;
      protection_en      <= 1'b0;
      recloser_en        <= 1'b0;
      comms_en           <= 1'b1;
      ready_led          <= 1'b0;
      error_msg          <= 1'b0;
      out_of_service     <= 1'b0;
      open_current_alarm <= 1'b0;
    end else begin
      sys_reset  <= (state_q == rscs_pkg::ST_RSTI);
      alarm      <= (state_q == rscs_pkg::ST_HALT) | dflt_settings_flag;
      outputs_en <= running;
      comms_en   <= 1'b1;
      trip_en        <= running & ~dflt_settings_flag;
      protection_en  <= running & ~dflt_settings_flag;
      recloser_en    <= running & ~dflt_settings_flag;
      out_of_service <= ~running | dflt_settings_flag;
      ready_led <= running;
      error_msg <= (state_q == rscs_pkg::ST_HALT);
      open_current_alarm <= open_cur_q;
    end
  end

  // Default settings image presented while fallback is in force.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dflt_set <= '0;
    end else if (dflt_settings_flag) begin
      dflt_set.duty_accum <= `RSCS_DUTY_ACCUM_DFLT;
      dflt_set.duty_limit <= `RSCS_DUTY_LIMIT_DFLT;
      dflt_set.permit     <= `RSCS_PERMIT_DFLT;
    end else begin
      dflt_set <= '0;
    end
  end

endmodule

`default_nettype wire

// ==== verification/rscs_tester_model.sv ====
// Model of the test units: answers each launch with the given results.
// Assumes the bench supplies result, sample and delay before the answer.
`timescale 1ns/1ps
`default_nettype none
module rscs_tester_model (
  input  wire logic                     clk,         // Clock.
  input  wire logic                     rst,         // Reset.
  input  wire logic                     test_start,  // Launch.
  input  wire rscs_pkg::rscs_test_res_t res_i,       // Result.
  input  wire logic [11:0]              code_i,      // Sample.
  input  wire logic [3:0]               dly_i,       // Delay.
  output rscs_pkg::rscs_test_res_t      test_res,    // Result out.
  output logic [11:0]                   adc_ref_code, // Sample out.
  output logic                          test_done    // Answer.
);
  logic [3:0] cnt_q; // Cycles left before the answer.
  // Answers after the delay; idle lines toggle so stale values never pass.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_q <= 4'h0;
      test_done <= 1'b0;
      test_res <= '0;
      adc_ref_code <= 12'h000;
    end else begin
      test_done <= 1'b0;
      test_res <= ~test_res;
      adc_ref_code <= ~adc_ref_code;
      if (test_start) begin
        cnt_q <= dly_i;
      end else if (cnt_q != 4'h0) begin
        cnt_q <= cnt_q - 4'h1;
        if (cnt_q == 4'h1) begin
          test_done <= 1'b1;
          test_res <= res_i;
          adc_ref_code <= code_i;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ==== verification/rscs_supervisor_checker.sv ====
// Assertions on the supervisor's ports, bound to every instance.
// Assumes one clock and the asynchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module rscs_checker #(
  parameter int unsigned WDOG_CYC = 200, // Watchdog timeout.
  parameter int unsigned ADC_W    = 12   // Converter width.
) (
  input wire logic                   clk,                 // Clock.
  input wire logic                   rst,                 // Reset.
  input wire logic                   settings_written,    // Rewrite.
  input wire logic                   breaker_open,        // Open.
  input wire logic                   current_present,     // Current.
  input wire logic                   test_start,          // Launch.
  input wire logic                   test_idle,           // Idle run.
  input wire logic                   sys_reset,           // Reset out.
  input wire logic                   alarm,               // Alarm.
  input wire logic                   outputs_en,          // Outputs.
  input wire logic                   trip_en,             // Trips.
  input wire logic                   protection_en,       // Protection.
  input wire logic                   recloser_en,         // Reclosing.
  input wire logic                   comms_en,            // Comms.
  input wire logic                   ready_led,           // Ready.
  input wire logic                   error_msg,           // Error text.
  input wire logic                   out_of_service,      // Out of svc.
  input wire logic                   hardware_fault_flag, // Chip fault.
  input wire logic                   dflt_settings_flag,  // Fallback.
  input wire logic                   open_current_alarm,  // Open with I.
  input wire rscs_pkg::rscs_dflt_set_t dflt_set,          // Defaults.
  input wire rscs_pkg::rscs_events_t   events             // Events.
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  logic [7:0] hold_q; // Cycles the reset line has been high.
  // Counts the length of each system reset pulse.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) hold_q <= 8'h00;
    else hold_q <= sys_reset ? hold_q + 8'h01 : 8'h00;
  end
  sequence s_rst_end;
    $fell(sys_reset);
  endsequence
  sequence s_fallback;
    dflt_settings_flag && $past(dflt_settings_flag);
  endsequence
  AST_COLD_START: assert property (events.cold_boot |->
    test_start && !test_idle) else $error("cold boot without run");
  AST_HALT_OUT: assert property (error_msg |-> !ready_led && alarm &&
    !outputs_en && !protection_en && !recloser_en && comms_en)
    else $error("halt outputs wrong");
  AST_HALT_LATCH: assert property (error_msg |=> error_msg)
    else $error("halt left");
  AST_RST_LEN: assert property (sys_reset |-> hold_q < 8'h10)
    else $error("reset too long");
  AST_RST_HOLD: assert property (s_rst_end |-> hold_q == 8'h10 ||
    error_msg) else $error("reset too short");
  AST_RST_COLD: assert property (s_rst_end |-> ##[0:3]
    (events.cold_boot || error_msg)) else $error("no cold boot after reset");
  AST_HW_HALT: assert property ($rose(hardware_fault_flag) |->
    ##[0:2] error_msg) else $error("chip fault without halt");
  AST_DFLT_OFF: assert property (s_fallback |-> !protection_en &&
    !trip_en && alarm && out_of_service) else $error("fallback wrong");
  AST_DFLT_VAL: assert property (s_fallback |->
    dflt_set == 40'h0000_1f40_ff) else $error("default image wrong");
  AST_DFLT_HOLD: assert property (dflt_settings_flag &&
    !settings_written |=> dflt_settings_flag) else $error("flag lost");
  AST_OPEN_I: assert property (open_current_alarm ==
    $past(breaker_open && current_present, 2)) else $error("open alarm");
  AST_OPEN_EVT: assert property (events.open_current |=>
    open_current_alarm) else $error("open event");
  AST_RST_EVT: assert property (events.sys_reset |->
    $rose(sys_reset)) else $error("reset event");
endmodule
bind rscs_supervisor rscs_checker #(.WDOG_CYC(WDOG_CYC), .ADC_W(ADC_W))
  u_chk (.clk, .rst, .settings_written, .breaker_open, .current_present,
  .test_start, .test_idle, .sys_reset, .alarm, .outputs_en, .trip_en,
  .protection_en, .recloser_en, .comms_en, .ready_led, .error_msg,
  .out_of_service, .hardware_fault_flag, .dflt_settings_flag,
  .open_current_alarm, .dflt_set, .events);
`default_nettype wire

// ==== verification/testbench.sv ====
// Self-checking bench of the supervisor with a model of the test units.
// Assumes a short watchdog timeout; expectations come from the bench.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clk, rst, idle, test_done, wdog_kick_a, wdog_kick_b, test_start;
  logic breaker_open, current_present, settings_written, test_idle;
  logic sys_reset, alarm, outputs_en, trip_en, protection_en, recloser_en;
  logic comms_en, ready_led, error_msg, out_of_service, osc_fault;
  logic hardware_fault_flag, dflt_settings_flag, dflt_calib_flag;
  logic open_current_alarm, evlog_fault, set_copy_b, cal_copy_b;
  logic [11:0] adc_ref_code, code_q;
  logic [3:0]  dly_q;
  logic [7:0]  kcnt_q;
  logic [1:0]  kick_en;
  rscs_pkg::rscs_test_res_t test_res, res_q;
  rscs_pkg::rscs_dflt_set_t dflt_set;
  rscs_pkg::rscs_events_t   events;
  int errors, n_compared, osc_e, ev_e, dfs_e, dfc_e;
  initial clk = 1'b0;
  always #2.5 clk = ~clk;
  rscs_supervisor #(.WDOG_CYC(200)) u_dut (.clk, .rst, .idle, .test_done,
    .test_res, .adc_ref_code, .wdog_kick_a, .wdog_kick_b, .breaker_open,
    .current_present, .settings_written, .test_start, .test_idle,
    .sys_reset, .alarm, .outputs_en, .trip_en, .protection_en,
    .recloser_en, .comms_en, .ready_led, .error_msg, .out_of_service,
    .hardware_fault_flag, .dflt_settings_flag, .dflt_calib_flag,
    .open_current_alarm, .osc_fault, .evlog_fault, .set_copy_b,
    .cal_copy_b, .dflt_set, .events);
  rscs_tester_model u_tst (.clk, .rst, .test_start, .res_i(res_q),
    .code_i(code_q), .dly_i(dly_q), .test_res, .adc_ref_code, .test_done);
  // Kicks the enabled watchdogs at staggered points.
  always @(posedge clk) begin
    kcnt_q <= kcnt_q + 8'h01;
    wdog_kick_a <= kick_en[0] && kcnt_q[5:0] == 6'h00;
    wdog_kick_b <= kick_en[1] && kcnt_q[5:0] == 6'h08;
  end
  task automatic chk(input string nm, input logic [63:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask
  task automatic print_verdict();
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic do_reset();
    @(posedge clk);
    rst <= 1'b1;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    {osc_e, ev_e, dfs_e, dfc_e} = '0;
  endtask
  // One test run: expected reaction worked out from the result given.
  task automatic run(input logic [9:0] r, input logic [11:0] c, input int ir);
    int crit, halt, rsti, n;
    @(posedge clk);
    if (c == 12'h000) c = 12'h7f0 + 12'($urandom % 33);
    res_q <= r;
    code_q <= c;
    dly_q <= 4'h1 + 4'($urandom % 8);
    idle <= ir[0];
    n = 0;
    while (test_done !== 1'b1 && n < 3000) begin
      @(posedge clk);
      #1;
      n++;
    end
    if (n == 3000) errors++;
    idle <= 1'b0;
    chk("test_idle", test_idle, ir);
    crit = r[9] | r[8] | r[6] | (c > 12'h810) | (c < 12'h7f0);
    halt = (crit & !ir) | r[4];
    rsti = crit & ir & !r[4];
    osc_e |= r[7];
    ev_e |= r[5];
    dfs_e |= r[3] & r[2];
    dfc_e |= r[1] & r[0];
    repeat (3) @(posedge clk);
    #1;
    chk("error_msg", error_msg, halt);
    chk("sys_reset", sys_reset, rsti);
    if (rsti) return;
    chk("alarm", alarm, halt | dfs_e);
    chk("protection_en", protection_en, !halt & !dfs_e);
    chk("comms_en", comms_en, 1);
    chk("hw_flag", hardware_fault_flag, r[4]);
    chk("osc_fault", osc_fault, osc_e);
    chk("evlog_fault", evlog_fault, ev_e);
    chk("dflt_settings", dflt_settings_flag, dfs_e);
    chk("dflt_calib", dflt_calib_flag, dfc_e);
    if (!dfs_e) chk("ready_led", ready_led, !halt);
    if (dfs_e) chk("dflt_set", dflt_set, 40'h0000_1f40_ff);
    if (r[3] ^ r[2]) chk("set_copy_b", set_copy_b, r[3]);
    if (r[1] ^ r[0]) chk("cal_copy_b", cal_copy_b, r[1]);
  endtask
  initial begin
    logic [21:0] tab [5];
    int n;
    tab = '{22'h200000, 22'h100000, 22'h040000, 22'h0007ef, 22'h000811};
    {rst, idle, breaker_open, current_present, settings_written} = 5'h10;
    {res_q, code_q, dly_q, kcnt_q, wdog_kick_a, wdog_kick_b} = '0;
    {kick_en, errors, n_compared} = {2'b11, 64'h0};
    void'($urandom(36465));
    do_reset();
    run(10'h000, 12'h000, 0);
    run(10'h0a0, 12'h000, 1);
    run(10'h008, 12'h000, 1);
    run(10'h00c, 12'h000, 1);
    @(posedge clk);
    settings_written <= 1'b1;
    @(posedge clk);
    settings_written <= 1'b0;
    {breaker_open, current_present} <= 2'b11;
    repeat (3) @(posedge clk);
    #1;
    chk("dflt_settings", dflt_settings_flag, 0);
    chk("open_alarm", open_current_alarm, 1);
    {breaker_open, current_present} <= 2'b00;
    dfs_e = 0;
    foreach (tab[i]) begin
      run(tab[i][21:12], tab[i][11:0], 1);
      run(10'h000, 12'h000, 0);
    end
    for (int i = 0; i < 2; i++) begin
      kick_en <= 2'b01 << i;
      n = 0;
      while (sys_reset !== 1'b1 && n < 600) begin
        @(posedge clk);
        #1;
        n++;
      end
      chk("wdog_reset", sys_reset, 1);
      kick_en <= 2'b11;
      run(10'h000, 12'h000, 0);
    end
    run(10'h002, 12'h000, 1);
    run(10'h003, 12'h000, 1);
    wait (wdog_kick_b === 1'b1);
    @(posedge clk);
    kick_en <= 2'b00;
    repeat (250) @(posedge clk);
    #1;
    chk("rsti_halt", error_msg, 1);
    kick_en <= 2'b11;
    do_reset();
    run(10'h200, 12'h000, 0);
    repeat (40) @(posedge clk);
    #1;
    chk("halt_held", error_msg, 1);
    do_reset();
    run(10'h010, 12'h000, 0);
    print_verdict();
  end
  initial begin
    repeat (60000) @(posedge clk);
    errors++;
    print_verdict();
  end
endmodule
`default_nettype wire
